// ==== common/irq_prio_pkg.sv ====
// package for the interrupt priority control register block
// assumes a 32-bit apb slave with a control word at offset 0x0 and a read-only status word at offset 0x4
package irq_prio_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] prio_ctrl_offset = 12'h000;
    localparam logic [11:0] prio_level_offset = 12'h004;
    localparam int reg_width = 16;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int prio_field_width = 3;
    localparam int pwm_gen_one_lsb = 12;
    localparam int special_event_match_lsb = 8;
    localparam int ext_irq_two_lsb = 4;
    localparam int ext_irq_one_lsb = 0;
    localparam int num_sources = 4;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [2:0] prio_reset = 3'h4;
    localparam logic [2:0] prio_disabled = 3'h0;
    localparam logic [2:0] prio_lowest = 3'h1;
    localparam logic [2:0] prio_highest = 3'h7;
    localparam logic [15:0] impl_mask = 16'h7777;

    typedef logic [2:0] prio_t;

    typedef struct packed {
        prio_t pwm_gen_one_priority;
        prio_t special_event_match_priority;
        prio_t ext_irq_two_priority;
        prio_t ext_irq_one_priority;
    } prio_set_t;

    typedef struct packed {
        logic [3:0] enabled;
        prio_t top_level;
        logic [1:0] top_source;
    } arb_view_t;

endpackage

// ==== design/prio_field_pick.sv ====
// combinational pick of the highest enabled priority among four fields
// assumes fields come from registers in the same clock domain
`timescale 1ns/1ps
module prio_field_pick
    import irq_prio_pkg::*;
(
    input wire prio_set_t fields,
    output arb_view_t view
);

    // ------------------------------------------------------------
    // pick
    // ------------------------------------------------------------
    prio_t lv [num_sources];

    always_comb begin
        lv[0] = fields.ext_irq_one_priority;
        lv[1] = fields.ext_irq_two_priority;
        lv[2] = fields.special_event_match_priority;
        lv[3] = fields.pwm_gen_one_priority;
        view.enabled = '0;
        view.top_level = prio_disabled;
        view.top_source = 2'h0;
        for (int i = 0; i < num_sources; i++) begin
            view.enabled[i] = (lv[i] != prio_disabled);
            if (lv[i] > view.top_level) begin
                view.top_level = lv[i];
                view.top_source = 2'(i);
            end
        end
    end

endmodule

// ==== design/irq_priority_ctrl_reg.sv ====
// interrupt priority control register with an apb slave port
// assumes a synchronous apb master on ref_clk and arbitration downstream
`timescale 1ns/1ps
module irq_priority_ctrl_reg
    import irq_prio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output prio_set_t prio_out,
    output logic [3:0] src_enabled
);

    // ------------------------------------------------------------
    // field storage
    // ------------------------------------------------------------
    prio_set_t fields_q, fields_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [3:0] en_q, en_d;
    arb_view_t view;
    logic access;
    logic hit_ctrl;
    logic hit_level;

    function automatic logic [15:0] pack_fields(input prio_set_t f);
        logic [15:0] r;
        r = '0;
        r[pwm_gen_one_lsb +: prio_field_width] = f.pwm_gen_one_priority;
        r[special_event_match_lsb +: prio_field_width] =
            f.special_event_match_priority;
        r[ext_irq_two_lsb +: prio_field_width] = f.ext_irq_two_priority;
        r[ext_irq_one_lsb +: prio_field_width] = f.ext_irq_one_priority;
        return r & impl_mask;
    endfunction

    function automatic prio_t field_at(input prio_set_t f,
                                       input logic [1:0] i);
        prio_t v;
        unique case (i)
            2'h0: v = f.ext_irq_one_priority;
            2'h1: v = f.ext_irq_two_priority;
            2'h2: v = f.special_event_match_priority;
            2'h3: v = f.pwm_gen_one_priority;
        endcase
        return v;
    endfunction

    prio_field_pick u_pick (
        .fields(fields_q),
        .view(view)
    );

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (num_sources != 4) begin
        $error("four priority sources are needed");
    end
    if (reg_width != 16) begin
        $error("the register word must be sixteen bits");
    end
    if (prio_field_width != $bits(prio_t)) begin
        $error("field width disagrees with the priority type");
    end
    if (pwm_gen_one_lsb + prio_field_width > reg_width) begin
        $error("pwm generator one field lies outside the word");
    end
    if (special_event_match_lsb + prio_field_width > pwm_gen_one_lsb) begin
        $error("special event field overlaps its neighbour");
    end
    if (ext_irq_two_lsb + prio_field_width > special_event_match_lsb) begin
        $error("external two field overlaps its neighbour");
    end
    if (ext_irq_one_lsb + prio_field_width > ext_irq_two_lsb) begin
        $error("external one field overlaps its neighbour");
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign access = psel && penable && !pready_q;
    assign hit_ctrl = (paddr == prio_ctrl_offset);
    assign hit_level = (paddr == prio_level_offset);

    always_comb begin
        fields_d = fields_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        en_d = view.enabled;
        if (access) begin
            pready_d = 1'b1;
            if (hit_ctrl) begin
                if (pwrite) begin
                    if (pstrb[1]) begin
                        fields_d.pwm_gen_one_priority =
                            pwdata[pwm_gen_one_lsb +: 3];
                        fields_d.special_event_match_priority =
                            pwdata[special_event_match_lsb +: 3];
                    end
                    if (pstrb[0]) begin
                        fields_d.ext_irq_two_priority =
                            pwdata[ext_irq_two_lsb +: 3];
                        fields_d.ext_irq_one_priority =
                            pwdata[ext_irq_one_lsb +: 3];
                    end
                end else begin
                    prdata_d = {16'h0000, pack_fields(fields_q)};
                end
            end else if (hit_level) begin
                if (pwrite) begin
                    pslverr_d = 1'b1;
                end else begin
                    prdata_d = {22'h0, view.top_source, 1'b0,
                                view.top_level, view.enabled};
                end
            end else begin
                pslverr_d = 1'b1;
                prdata_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fields_q <= '{prio_reset, prio_reset, prio_reset,
                          prio_reset};
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            en_q <= 4'hf;
        end else begin
            fields_q <= fields_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            en_q <= en_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prio_out = fields_q;
    assign src_enabled = en_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_pwm_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && pstrb[1] |=>
        prio_out.pwm_gen_one_priority == $past(pwdata[14:12]))
        else $error("pwm generator one field not written");
    chk_sem_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && pstrb[1] |=>
        prio_out.special_event_match_priority == $past(pwdata[10:8]))
        else $error("special event field not written");
    chk_ext2_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && pstrb[0] |=>
        prio_out.ext_irq_two_priority == $past(pwdata[6:4]))
        else $error("external two field not written");
    chk_ext1_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && pstrb[0] |=>
        prio_out.ext_irq_one_priority == $past(pwdata[2:0]))
        else $error("external one field not written");
    chk_pwm_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && !pstrb[1] |=>
        $stable(prio_out.pwm_gen_one_priority))
        else $error("pwm generator one field written without strobe");
    chk_sem_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && !pstrb[1] |=>
        $stable(prio_out.special_event_match_priority))
        else $error("special event field written without strobe");
    chk_ext2_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && !pstrb[0] |=>
        $stable(prio_out.ext_irq_two_priority))
        else $error("external two field written without strobe");
    chk_ext1_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_ctrl && !pstrb[0] |=>
        $stable(prio_out.ext_irq_one_priority))
        else $error("external one field written without strobe");
    chk_idle_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(access && pwrite && hit_ctrl) |=> $stable(prio_out))
        else $error("fields changed without a register write");

    // ------------------------------------------------------------
    // checks on read back
    // ------------------------------------------------------------
    chk_pwm_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit_ctrl |=>
        prdata[14:12] == $past(prio_out.pwm_gen_one_priority))
        else $error("pwm generator one field not read back");
    chk_sem_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit_ctrl |=>
        prdata[10:8] == $past(prio_out.special_event_match_priority))
        else $error("special event field not read back");
    chk_ext2_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit_ctrl |=>
        prdata[6:4] == $past(prio_out.ext_irq_two_priority))
        else $error("external two field not read back");
    chk_ext1_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit_ctrl |=>
        prdata[2:0] == $past(prio_out.ext_irq_one_priority))
        else $error("external one field not read back");
    chk_unimpl_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit_ctrl |=>
        (prdata & ~{16'h0000, impl_mask}) == 32'h00000000)
        else $error("unimplemented bits read nonzero");

    // ------------------------------------------------------------
    // checks on levels
    // ------------------------------------------------------------
    chk_top_highest: assert property (
        @(posedge ref_clk) disable iff (rst)
        fields_q.ext_irq_one_priority == prio_highest |->
        view.top_level == prio_highest)
        else $error("level seven not reported as highest");
    chk_top_lowest: assert property (
        @(posedge ref_clk) disable iff (rst)
        fields_q == prio_set_t'{prio_lowest, prio_disabled, prio_disabled,
                                prio_disabled} |->
        view.top_level == prio_lowest && view.top_source == 2'h3)
        else $error("level one not reported");
    chk_top_max: assert property (
        @(posedge ref_clk) disable iff (rst)
        view.top_level >= field_at(fields_q, 2'h0) &&
        view.top_level >= field_at(fields_q, 2'h1) &&
        view.top_level >= field_at(fields_q, 2'h2) &&
        view.top_level >= field_at(fields_q, 2'h3))
        else $error("a field stands above the reported level");
    chk_top_source: assert property (
        @(posedge ref_clk) disable iff (rst)
        view.enabled != 4'h0 |->
        field_at(fields_q, view.top_source) == view.top_level)
        else $error("reported source does not hold the level");
    chk_none_enabled: assert property (
        @(posedge ref_clk) disable iff (rst)
        view.enabled == 4'h0 |->
        view.top_level == prio_disabled)
        else $error("a level reported with every source disabled");
    chk_disable_src: assert property (
        @(posedge ref_clk) disable iff (rst)
        fields_q.ext_irq_one_priority == prio_disabled |=>
        !src_enabled[0])
        else $error("disabled source still enabled");
    chk_enable_map: assert property (
        @(posedge ref_clk) disable iff (rst)
        src_enabled == $past({
            fields_q.pwm_gen_one_priority != prio_disabled,
            fields_q.special_event_match_priority != prio_disabled,
            fields_q.ext_irq_two_priority != prio_disabled,
            fields_q.ext_irq_one_priority != prio_disabled}))
        else $error("enabled sources do not follow the fields");

    // ------------------------------------------------------------
    // checks on the bus answer
    // ------------------------------------------------------------
    chk_ready_answer: assert property (
        @(posedge ref_clk) disable iff (rst)
        access |=> pready)
        else $error("access not answered in the next cycle");
    chk_ready_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_unmapped_err: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && !hit_ctrl && !hit_level |=>
        pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    chk_status_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        access && pwrite && hit_level |=> pslverr && $stable(prio_out))
        else $error("status write not refused");
    chk_err_ready: assert property (
        @(posedge ref_clk) disable iff (rst)
        pslverr |-> pready)
        else $error("pslverr raised outside an answer");

    // ------------------------------------------------------------
    // checks on reset
    // ------------------------------------------------------------
    chk_reset_value: assert property (
        @(posedge ref_clk)
        !rst && $past(rst) |->
        prio_out == prio_set_t'{prio_reset, prio_reset, prio_reset,
                                prio_reset})
        else $error("fields not reset to level four");
    chk_reset_bus: assert property (
        @(posedge ref_clk)
        !rst && $past(rst) |->
        !pready && !pslverr && prdata == 32'h00000000 &&
        src_enabled == 4'hf)
        else $error("bus outputs not cleared by reset");

endmodule

// ==== dv/tb_irq_priority_ctrl_reg.sv ====
// self-checking bench for the interrupt priority control register
// assumes an apb slave that answers each transfer with a pready pulse
`timescale 1ns/1ps
module tb_irq_priority_ctrl_reg
    import irq_prio_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    prio_set_t prio_out;
    logic [3:0] src_enabled;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int n_tests = 0;

    always #12.5 ref_clk = ~ref_clk;

    irq_priority_ctrl_reg u_irq_priority_ctrl_reg (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prio_out(prio_out), .src_enabled(src_enabled)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // apb master
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("mismatch pready expected 1 seen %b", pready);
            test_done();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // write, read back word, fields, enables and status
    task automatic run_case(input logic [31:0] d, input logic [3:0] s,
                            input logic [15:0] w, input logic [11:0] f,
                            input logic [3:0] e, input logic [9:0] st);
        apb(1'b1, prio_ctrl_offset, d, s);
        chk("write error", {31'h0, err}, 32'h0);
        apb(1'b0, prio_ctrl_offset, 32'h0, 4'h0);
        chk("word", rd, {16'h0, w});
        chk("fields", {20'h0, prio_out}, {20'h0, f});
        chk("enabled", {28'h0, src_enabled}, {28'h0, e});
        apb(1'b0, prio_level_offset, 32'h0, 4'h0);
        chk("status", rd, {22'h0, st});
        $display("test write %h strobe %h done", d, s);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, prio_ctrl_offset, 32'h0, 4'h0);
        chk("reset word", rd, 32'h0000_4444);
        chk("reset fields", {20'h0, prio_out}, 32'h924);
        chk("reset enabled", {28'h0, src_enabled}, 32'hf);
        $display("test reset done");
        run_case(32'h0000_0000, 4'hf, 16'h0000, 12'h000, 4'h0, 10'h000);
        run_case(32'h0000_1000, 4'hf, 16'h1000, 12'h200, 4'h8, 10'h318);
        run_case(32'hffff_ffff, 4'hf, 16'h7777, 12'hfff, 4'hf, 10'h07f);
        run_case(32'h0000_1234, 4'hf, 16'h1234, 12'h29c, 4'hf, 10'h04f);
        run_case(32'h0000_0705, 4'hf, 16'h0705, 12'h1c5, 4'h5, 10'h275);
        run_case(32'h0000_7777, 4'h1, 16'h0777, 12'h1ff, 4'h7, 10'h077);
        run_case(32'hffff_0000, 4'h2, 16'h0077, 12'h03f, 4'h3, 10'h073);
        run_case(32'h0000_6000, 4'h2, 16'h6077, 12'hc3f, 4'hb, 10'h07b);
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, prio_level_offset, 32'h0, 4'hf);
        chk("status write error", {31'h0, err}, 32'h1);
        apb(1'b0, prio_ctrl_offset, 32'h0, 4'h0);
        chk("word kept", rd, 32'h0000_6077);
        $display("test refused accesses done");
        test_done();
    end
endmodule
